// File: pkg/bws_pkg.sv
// Overview of operation
// - lin failure code: 01 thermal, 10 transmit input stuck, 11 bus stuck, over 20ms.
// - can failure code: 01 thermal, 10 transmit input stuck, 11 bus stuck, timeout period.
// - can supply undervoltage sets bit 0 and turns the can transmitter off.
// - undervoltage comparator runs only while can mode bit one is set.
// - transmit input stuck ends when input goes high or transceiver leaves active mode.
// - bus stuck ends when bus goes recessive or transceiver leaves active mode.
// - undervoltage ends as soon as the supply is back above threshold.
// - after any fault, transmit resumes only after input stayed high for enable time.
// - can timeout flag sets on silence only with selective wake enabled, and sticks.
// - can timeout raises an interrupt in normal or stop mode when its mask is set.
// - system error sets on configuration error or counter overflow, only in selective wake.
// - selective wake cannot be activated while the system error flag is set.
// - can timeout flag cannot be cleared until the next falling edge of the interrupt.
// - wake flags: lin bit 6, can bit 5, timer bit 4, wake pins bits 2 to 0.
// - a wake out of fail-safe mode also sets the matching wake flag.
// - gpio wake flags at bits 5 and 4 of the second wake register; rest zero.
// - level register bit 7 shows the development mode strap of the test pin.
// - level register bit 6 shows the pull-up strap on the interrupt pin.
// - gpio levels update in normal and stop modes when used as wake or switch.
// - in cyclic sense the wake pin levels hold the latest sample.
// - a pin selected as gpio shows its level even when used as a switch.
// - reserved bits of all these registers read zero.
// - frame error counter counts down on valid frames; at 32 disables selective wake.
package bws_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned LIN_DOM_TIME_US = 20000;
  localparam int unsigned CAN_TO_TIME_US = 1000;
  localparam int unsigned TXEN_TIME_US = 10;
  localparam int unsigned INT_PULSE_TIME_US = 1;
  localparam int unsigned LIN_DOM_CYC = LIN_DOM_TIME_US * CLK_MHZ;
  localparam int unsigned CAN_TO_CYC = CAN_TO_TIME_US * CLK_MHZ;
  localparam int unsigned TXEN_CYC = TXEN_TIME_US * CLK_MHZ;
  localparam int unsigned INT_CYC = INT_PULSE_TIME_US * CLK_MHZ;
  localparam int unsigned CW = 23;
  localparam logic [6:0] ADDR_BUS_COMM = 7'h44;
  localparam logic [6:0] ADDR_WAKE_A = 7'h46;
  localparam logic [6:0] ADDR_WAKE_B = 7'h47;
  localparam logic [6:0] ADDR_LEVEL = 7'h48;
  localparam logic [1:0] FAIL_NONE = 2'h0;
  localparam logic [1:0] FAIL_TSD = 2'h1;
  localparam logic [1:0] FAIL_TXD = 2'h2;
  localparam logic [1:0] FAIL_BUS = 2'h3;
  localparam logic [5:0] ECNT_LIMIT = 6'h20;
  localparam int unsigned CAN_MODE_ACTIVE_BIT = 1;
  localparam int unsigned CAN_MODE_SWK_BIT = 2;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {SBC_INIT, SBC_NORMAL, SBC_STOP, SBC_SLEEP, SBC_RESTART,
    SBC_FAILSAFE} bws_mode_t;
  typedef enum logic [1:0] {GPIO_OFF, GPIO_WAKE, GPIO_LOW_SIDE, GPIO_HIGH_SIDE} bws_gpio_cfg_t;

  // pins that reach the block from outside its clock
  typedef struct packed {
    logic linTxd;
    logic linBus;
    logic canTxd;
    logic canBus;
    logic [2:0] wakePin;
    logic [1:0] gpioPin;
    logic testPin;
    logic cfgPullupPin;
  } bws_pins_t;

  // same-clock events from the transceivers and the wake logic
  typedef struct packed {
    logic linTsd;
    logic canTsd;
    logic canUvRaw;
    logic canSilence;
    logic swkCfgErr;
    logic swkValidFrame;
    logic swkFrameErr;
    logic swkRequest;
    logic [6:0] wakeEvt;
    logic [1:0] gpioWakeEvt;
    logic wakeSample;
  } bws_evt_t;

  typedef struct packed {
    logic [1:0] linFail;
    logic canTimeout;
    logic selective_wake_system_error;
    logic [1:0] canFail;
    logic canUv;
    logic [6:0] wakeA;
    logic [1:0] wakeB;
    logic [4:0] pinLvl;
    logic [1:0] strap;
    logic strapTaken;
    logic [CW-1:0] linTxdCnt;
    logic [CW-1:0] linBusCnt;
    logic [CW-1:0] canTxdCnt;
    logic [CW-1:0] canBusCnt;
    logic [CW-1:0] linEnCnt;
    logic [CW-1:0] canEnCnt;
    logic linTxdStuck;
    logic linBusStuck;
    logic canTxdStuck;
    logic canBusStuck;
    logic linBlk;
    logic canBlk;
    logic [5:0] errCnt;
    logic clrBlock;
    logic [CW-1:0] intCnt;
    bws_pins_t sync1;
    bws_pins_t sync2;
    logic [7:0] rdata;
    logic rvalid;
    logic canTxEn;
    logic linTxEn;
    logic intN;
    logic swkActive;
    logic canWakeEn;
    logic uvCompEn;
  } bws_state_t;
endpackage : bws_pkg

// File: core/bws_status_bank.sv
module bws_status_bank #(
  parameter int unsigned LIN_DOM_CYC = bws_pkg::LIN_DOM_CYC,
  parameter int unsigned CAN_TO_CYC = bws_pkg::CAN_TO_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire bws_pkg::bws_pins_t pins,
  input wire bws_pkg::bws_evt_t evt,
  input wire bws_pkg::bws_mode_t sbcMode,
  input wire logic [2:0] canMode,
  input wire logic linActive,
  input wire logic canTimeoutMask,
  input wire bws_pkg::bws_gpio_cfg_t gpio1Cfg,
  input wire bws_pkg::bws_gpio_cfg_t gpio2Cfg,
  input wire logic [6:0] regAddr,
  input wire logic regRd,
  input wire logic regClr,
  output logic [7:0] regRdata,
  output logic regRvalid,
  output logic canTxEn,
  output logic linTxEn,
  output logic intN,
  output logic swkActive,
  output logic canWakeEn,
  output logic uvCompEn
);
  bws_pkg::bws_state_t q;
  bws_pkg::bws_state_t d;

  // saturating run-length counter, zero when the condition drops
  function automatic logic [bws_pkg::CW-1:0] runCnt(input logic [bws_pkg::CW-1:0] c,
                                                    input logic cond);
    logic [bws_pkg::CW-1:0] r;
    r = '0;
    if (cond) begin
      r = (&c) ? c : c + 1'b1;
    end
    return r;
  endfunction : runCnt

  function automatic logic [1:0] failCode(input logic thermal_shutdown, input logic txd, input logic bus);
    logic [1:0] r;
    r = bws_pkg::FAIL_NONE;
    if (thermal_shutdown) begin
      r = bws_pkg::FAIL_TSD;
    end else if (txd) begin
      r = bws_pkg::FAIL_TXD;
    end else if (bus) begin
      r = bws_pkg::FAIL_BUS;
    end
    return r;
  endfunction : failCode

  function automatic logic gpioLive(input bws_pkg::bws_gpio_cfg_t cfg);
    return cfg != bws_pkg::GPIO_OFF;
  endfunction : gpioLive

  logic canActive;
  logic swkEn;
  logic runMode;
  logic clrBus;
  logic clrWakeA;
  logic clrWakeB;
  logic [1:0] linCode;
  logic [1:0] canCode;
  logic canUvNow;
  logic linFault;
  logic canFault;
  logic canToRise;
  logic [bws_pkg::CW-1:0] linDomLim;
  logic [bws_pkg::CW-1:0] canToLim;
  logic [bws_pkg::CW-1:0] txenLim;
  logic [bws_pkg::CW-1:0] intLim;

  assign linDomLim = bws_pkg::CW'(LIN_DOM_CYC);
  assign canToLim = bws_pkg::CW'(CAN_TO_CYC);
  assign txenLim = bws_pkg::CW'(bws_pkg::TXEN_CYC);
  assign intLim = bws_pkg::CW'(bws_pkg::INT_CYC);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.sync1 = pins;
    d.sync2 = q.sync1;
    canActive = canMode[bws_pkg::CAN_MODE_ACTIVE_BIT];
    swkEn = canMode[bws_pkg::CAN_MODE_SWK_BIT];
    runMode = (sbcMode == bws_pkg::SBC_NORMAL) || (sbcMode == bws_pkg::SBC_STOP);
    clrBus = regRd && regClr && (regAddr == bws_pkg::ADDR_BUS_COMM);
    clrWakeA = regRd && regClr && (regAddr == bws_pkg::ADDR_WAKE_A);
    clrWakeB = regRd && regClr && (regAddr == bws_pkg::ADDR_WAKE_B);

    // stuck timers only run while the transceiver is active
    d.linTxdCnt = runCnt(q.linTxdCnt, linActive && !q.sync2.linTxd);
    d.linBusCnt = runCnt(q.linBusCnt, linActive && !q.sync2.linBus);
    d.canTxdCnt = runCnt(q.canTxdCnt, canActive && !q.sync2.canTxd);
    d.canBusCnt = runCnt(q.canBusCnt, canActive && !q.sync2.canBus);
    d.linTxdStuck = linActive && !q.sync2.linTxd &&
                    (q.linTxdStuck || q.linTxdCnt >= linDomLim);
    d.linBusStuck = linActive && !q.sync2.linBus &&
                    (q.linBusStuck || q.linBusCnt >= linDomLim);
    d.canTxdStuck = canActive && !q.sync2.canTxd &&
                    (q.canTxdStuck || q.canTxdCnt >= canToLim);
    d.canBusStuck = canActive && !q.sync2.canBus &&
                    (q.canBusStuck || q.canBusCnt >= canToLim);

    linCode = failCode(evt.linTsd, q.linTxdStuck, q.linBusStuck);
    canCode = failCode(evt.canTsd, q.canTxdStuck, q.canBusStuck);
    canUvNow = canActive && evt.canUvRaw;
    d.uvCompEn = canActive;

    // clear first, then a live condition sets again so it is never lost
    d.linFail = clrBus ? bws_pkg::FAIL_NONE : q.linFail;
    if (linCode != bws_pkg::FAIL_NONE) begin
      d.linFail = linCode;
    end
    d.canFail = clrBus ? bws_pkg::FAIL_NONE : q.canFail;
    if (canCode != bws_pkg::FAIL_NONE) begin
      d.canFail = canCode;
    end
    d.canUv = (q.canUv && !clrBus) || canUvNow;

    // transmit re-enable waits for a quiet high transmit input
    linFault = evt.linTsd || q.linTxdStuck || q.linBusStuck;
    canFault = evt.canTsd || q.canTxdStuck || q.canBusStuck || canUvNow;
    d.linEnCnt = runCnt(q.linEnCnt, q.linBlk && !linFault && q.sync2.linTxd);
    d.canEnCnt = runCnt(q.canEnCnt, q.canBlk && !canFault && q.sync2.canTxd);
    d.linBlk = linFault || (q.linBlk && q.linEnCnt < txenLim);
    d.canBlk = canFault || (q.canBlk && q.canEnCnt < txenLim);
    d.linTxEn = linActive && !d.linBlk;
    d.canTxEn = canActive && !d.canBlk;

    // selective wake error counting
    if (swkEn) begin
      if (evt.swkFrameErr && q.errCnt < bws_pkg::ECNT_LIMIT) begin
        d.errCnt = q.errCnt + 6'h01;
      end else if (evt.swkValidFrame && q.errCnt != 6'h00) begin
        d.errCnt = q.errCnt - 6'h01;
      end
    end
    // a clear at the limit also empties the counter, so an overflow seen in that cycle must not re-set
    d.selective_wake_system_error = (q.selective_wake_system_error && !clrBus) ||
               (swkEn && (evt.swkCfgErr ||
                          (q.errCnt == bws_pkg::ECNT_LIMIT && !clrBus)));
    d.swkActive = swkEn && evt.swkRequest && !d.selective_wake_system_error;
    d.canWakeEn = q.canWakeEn || (q.errCnt == bws_pkg::ECNT_LIMIT);
    if (clrBus && q.errCnt == bws_pkg::ECNT_LIMIT) begin
      d.errCnt = 6'h00;
      d.canWakeEn = 1'b0;
    end

    // can timeout, interrupt pulse and the clear lock
    canToRise = swkEn && evt.canSilence && !q.canTimeout;
    d.canTimeout = (q.canTimeout && !(clrBus && !q.clrBlock)) ||
                   (swkEn && evt.canSilence);
    if (canToRise) begin
      d.clrBlock = 1'b1;
    end
    d.intCnt = (q.intCnt != '0) ? q.intCnt - 1'b1 : '0;
    if (canToRise && runMode && canTimeoutMask) begin
      d.intCnt = intLim;
      d.clrBlock = 1'b0;
    end
    d.intN = (d.intCnt == '0);

    // wake sources, including a wake out of fail-safe
    d.wakeA = (clrWakeA ? 7'h00 : q.wakeA) | evt.wakeEvt;
    d.wakeB = (clrWakeB ? 2'h0 : q.wakeB) | evt.gpioWakeEvt;

    // straps are caught once, just after reset is released
    if (!q.strapTaken) begin
      d.strap = {q.sync2.testPin, q.sync2.cfgPullupPin};
      d.strapTaken = 1'b1;
    end
    if (runMode && gpioLive(gpio1Cfg)) begin
      d.pinLvl[3] = q.sync2.gpioPin[0];
    end
    if (runMode && gpioLive(gpio2Cfg)) begin
      d.pinLvl[4] = q.sync2.gpioPin[1];
    end
    // cyclic sense holds the last sample; static sense follows the pin
    if (evt.wakeSample || runMode) begin
      d.pinLvl[2:0] = q.sync2.wakePin;
    end

    // read port, unmapped addresses return zero
    d.rvalid = regRd;
    d.rdata = bws_pkg::RESET_BYTE;
    if (regRd) begin
      unique case (regAddr)
        bws_pkg::ADDR_BUS_COMM: d.rdata = {1'b0, q.linFail, q.canTimeout, q.selective_wake_system_error,
                                           q.canFail, q.canUv};
        bws_pkg::ADDR_WAKE_A: d.rdata = {1'b0, q.wakeA[6:4], 1'b0, q.wakeA[2:0]};
        bws_pkg::ADDR_WAKE_B: d.rdata = {2'h0, q.wakeB, 4'h0};
        bws_pkg::ADDR_LEVEL: d.rdata = {q.strap, q.pinLvl[4:3], 1'b0,
                                        q.pinLvl[2:0]};
        default: d.rdata = bws_pkg::RESET_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.intN <= 1'b1;
      // synchronisers keep running so straps and pin levels are valid at release
      q.sync1 <= d.sync1;
      q.sync2 <= d.sync2;
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign regRvalid = q.rvalid;
  assign canTxEn = q.canTxEn;
  assign linTxEn = q.linTxEn;
  assign intN = q.intN;
  assign swkActive = q.swkActive;
  assign canWakeEn = q.canWakeEn;
  assign uvCompEn = q.uvCompEn;

  ////////////////////////////////////////////////////////////////////////////////
  a_uv_tx_off: assert property (@(posedge core_clk) disable iff (srst)
    (canActive && evt.canUvRaw) |=> (q.canUv && !canTxEn))
    else $error("can undervoltage did not flag or stop transmitter");
  a_uv_comp_gate: assert property (@(posedge core_clk) disable iff (srst)
    (!canActive && evt.canUvRaw && !q.canUv && !clrBus) |=> !q.canUv)
    else $error("undervoltage flagged with comparator disabled");
  a_can_timeout_flag_swk_only: assert property (@(posedge core_clk) disable iff (srst)
    (!q.canTimeout && !swkEn) |=> !q.canTimeout)
    else $error("can timeout set without selective wake");
  a_can_timeout_flag_sticky: assert property (@(posedge core_clk) disable iff (srst)
    (q.canTimeout && !clrBus) |=> q.canTimeout)
    else $error("can timeout dropped without a clear");
  a_int_pulse: assert property (@(posedge core_clk) disable iff (srst)
    (canToRise && runMode && canTimeoutMask) |=> !intN [*8])
    else $error("interrupt pulse missing after can timeout");
  a_can_timeout_flag_lock: assert property (@(posedge core_clk) disable iff (srst)
    (q.canTimeout && q.clrBlock) |=> q.canTimeout)
    else $error("can timeout cleared while locked");
  a_swk_selective_wake_system_error: assert property (@(posedge core_clk) disable iff (srst)
    (q.selective_wake_system_error && !clrBus) |=> !swkActive)
    else $error("selective wake active with system error");
  a_ecnt_limit: assert property (@(posedge core_clk) disable iff (srst)
    (swkEn && q.errCnt == bws_pkg::ECNT_LIMIT && !clrBus) |=>
    (q.selective_wake_system_error && canWakeEn && !swkActive))
    else $error("counter overflow did not disable selective wake");
  a_wake_latch: assert property (@(posedge core_clk) disable iff (srst)
    (evt.wakeEvt[5] && !clrWakeA) |=> q.wakeA[5] ##1 (q.wakeA[5] || $past(clrWakeA)))
    else $error("can wake flag not latched");
  a_txen_wait: assert property (@(posedge core_clk) disable iff (srst)
    (evt.linTsd) |=> !linTxEn [*8])
    else $error("lin transmitter re-enabled too soon after fault");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (srst)
    regRvalid |-> (!regRdata[7] || $past(regAddr) == bws_pkg::ADDR_LEVEL))
    else $error("reserved bit 7 read as one");
endmodule : bws_status_bank

// File: tb/bws_host_model.sv
module bws_host_model (
  input wire logic core_clk,
  output logic [6:0] regAddr,
  output logic regRd,
  output logic regClr,
  input wire logic [7:0] regRdata,
  input wire logic regRvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regAddr = 7'h00;
    regRd = 1'b0;
    regClr = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one read, optionally clearing; the answer is taken once regRvalid shows
  task automatic access(input logic [6:0] a, input logic c, output logic [7:0] d,
                        output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge core_clk);
    regAddr <= a;
    regClr <= c;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    regClr <= 1'b0;
    for (int n = 0; n < 3 && !ok; n++) begin
      @(posedge core_clk);
      if (regRvalid === 1'b1) begin
        d = regRdata;
        ok = 1'b1;
      end
    end
  endtask : access
endmodule : bws_host_model

// File: tb/bws_status_bank_tb.sv
module bws_status_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  bws_pkg::bws_pins_t pins;
  bws_pkg::bws_evt_t evt;
  bws_pkg::bws_mode_t sbcMode;
  logic [2:0] canMode;
  logic linActive, canTimeoutMask;
  bws_pkg::bws_gpio_cfg_t gpio1Cfg, gpio2Cfg;
  logic [6:0] regAddr;
  logic regRd, regClr, regRvalid, canTxEn, linTxEn, intN, swkActive, canWakeEn, uvCompEn;
  logic [7:0] regRdata;
  logic [7:0] expTab [6] = '{8'h04, 8'h06, 8'h40, 8'h60, 8'h20, 8'h02};
  int badCount = 0;
  int checked = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  bws_status_bank #(.LIN_DOM_CYC(20), .CAN_TO_CYC(20)) i_bws_status_bank (
    .core_clk(core_clk), .srst(srst), .pins(pins), .evt(evt), .sbcMode(sbcMode),
    .canMode(canMode), .linActive(linActive), .canTimeoutMask(canTimeoutMask),
    .gpio1Cfg(gpio1Cfg), .gpio2Cfg(gpio2Cfg), .regAddr(regAddr), .regRd(regRd),
    .regClr(regClr), .regRdata(regRdata), .regRvalid(regRvalid), .canTxEn(canTxEn),
    .linTxEn(linTxEn), .intN(intN), .swkActive(swkActive), .canWakeEn(canWakeEn),
    .uvCompEn(uvCompEn));
  bws_host_model i_bws_host_model (.core_clk(core_clk), .regAddr(regAddr), .regRd(regRd),
    .regClr(regClr), .regRdata(regRdata), .regRvalid(regRvalid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (badCount == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("ERROR %0t read %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      badCount++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_bws_host_model.access(a, c, d, ok);
    chk1(ok, 1'b1);
    chk8(d, e);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  // low 13 bits of evt: validFrame, frameErr, request, wakeEvt, gpioWakeEvt, wakeSample
  task automatic pw(input logic [12:0] m);
    @(posedge core_clk) evt[12:0] <= evt[12:0] | m;
    @(posedge core_clk) evt[12:0] <= evt[12:0] & ~m;
  endtask : pw
  task automatic setf(input int i, input logic v);
    case (i)
      0: pins.canTxd <= ~v;
      1: pins.canBus <= ~v;
      2: pins.linTxd <= ~v;
      3: pins.linBus <= ~v;
      4: evt.linTsd <= v;
      default: evt.canTsd <= v;
    endcase
  endtask : setf
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      badCount++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pins = '1;
    pins.wakePin = 3'h5;
    pins.gpioPin = 2'h2;
    evt = '0;
    sbcMode = bws_pkg::SBC_NORMAL;
    canMode = 3'h2;
    linActive = 1'b1;
    canTimeoutMask = 1'b1;
    gpio1Cfg = bws_pkg::GPIO_WAKE;
    gpio2Cfg = bws_pkg::GPIO_WAKE;
    idle(5);
    srst <= 1'b0;
    idle(4);
    rd(7'h44, 0, 8'h00);
    rd(7'h46, 0, 8'h00);
    rd(7'h47, 0, 8'h00);
    rd(7'h45, 0, 8'h00);
    rd(7'h48, 0, 8'he5);
    gpio1Cfg <= bws_pkg::GPIO_LOW_SIDE;
    pins.gpioPin <= 2'h1;
    idle(4);
    rd(7'h48, 0, 8'hd5);
    sbcMode <= bws_pkg::SBC_SLEEP;
    pins.wakePin <= 3'h2;
    idle(4);
    rd(7'h48, 0, 8'hd5);
    pw(13'h0001);
    rd(7'h48, 0, 8'hd2);
    sbcMode <= bws_pkg::SBC_NORMAL;
    pw(13'h03f8);
    rd(7'h46, 1, 8'h77);
    rd(7'h46, 0, 8'h00);
    pw(13'h0006);
    rd(7'h47, 1, 8'h30);
    rd(7'h47, 0, 8'h00);
    sbcMode <= bws_pkg::SBC_FAILSAFE;
    pw(13'h0100);
    rd(7'h46, 1, 8'h20);
    sbcMode <= bws_pkg::SBC_NORMAL;
    // transmit input stays high from reset on, so both transmitters come up
    idle(2100);
    chk1(canTxEn, 1'b1);
    chk1(linTxEn, 1'b1);
    evt.canUvRaw <= 1'b1;
    idle(3);
    chk1(uvCompEn, 1'b1);
    chk1(canTxEn, 1'b0);
    rd(7'h44, 1, 8'h01);
    evt.canUvRaw <= 1'b0;
    rd(7'h44, 1, 8'h01);
    rd(7'h44, 0, 8'h00);
    idle(1890);
    chk1(canTxEn, 1'b0);
    idle(150);
    chk1(canTxEn, 1'b1);
    canMode <= 3'h0;
    idle(2);
    chk1(uvCompEn, 1'b0);
    canMode <= 3'h2;
    for (int i = 0; i < 6; i++) begin
      setf(i, 1'b1);
      idle(40);
      rd(7'h44, 1, expTab[i]);
      setf(i, 1'b0);
      idle(3);
      rd(7'h44, 1, expTab[i]);
      rd(7'h44, 0, 8'h00);
    end
    pins.canTxd <= 1'b0;
    idle(40);
    canMode <= 3'h0;
    idle(3);
    rd(7'h44, 1, 8'h04);
    rd(7'h44, 0, 8'h00);
    pins.canTxd <= 1'b1;
    canMode <= 3'h2;
    // silence without selective wake must not flag a timeout
    evt.canSilence <= 1'b1;
    idle(3);
    evt.canSilence <= 1'b0;
    rd(7'h44, 0, 8'h00);
    canMode <= 3'h6;
    evt.canSilence <= 1'b1;
    idle(3);
    evt.canSilence <= 1'b0;
    chk1(intN, 1'b0);
    idle(250);
    chk1(intN, 1'b1);
    rd(7'h44, 1, 8'h10);
    rd(7'h44, 0, 8'h00);
    repeat (31) pw(13'h0800);
    pw(13'h1000);
    pw(13'h0800);
    rd(7'h44, 0, 8'h00);
    pw(13'h0800);
    rd(7'h44, 0, 8'h08);
    chk1(canWakeEn, 1'b1);
    evt.swkRequest <= 1'b1;
    idle(3);
    chk1(swkActive, 1'b0);
    rd(7'h44, 1, 8'h08);
    idle(3);
    chk1(swkActive, 1'b1);
    evt.swkRequest <= 1'b0;
    canMode <= 3'h2;
    evt.swkCfgErr <= 1'b1;
    rd(7'h44, 0, 8'h00);
    canMode <= 3'h6;
    idle(3);
    evt.swkCfgErr <= 1'b0;
    rd(7'h44, 1, 8'h08);
    rd(7'h44, 0, 8'h00);
    // masked timeout gives no pulse, so the flag stays locked until reset
    canTimeoutMask <= 1'b0;
    evt.canSilence <= 1'b1;
    idle(3);
    evt.canSilence <= 1'b0;
    chk1(intN, 1'b1);
    rd(7'h44, 1, 8'h10);
    rd(7'h44, 1, 8'h10);
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    idle(4);
    rd(7'h44, 0, 8'h00);
    chk1(intN, 1'b1);
    stop_test();
  end
endmodule : bws_status_bank_tb
